// *** design/stby_regs.svh ***
`ifndef STBY_REGS_SVH
`define STBY_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define STBY_CTRL_OFS       12'h000
`define STBY_STAT_OFS       12'h004
`define STBY_CTRL_RST       5'h00
`define STBY_OSC_SETTLE_TIME_SELECT_LSB       0
`define STBY_OSC_SETTLE_TIME_SELECT_MSB       1
`define STBY_XTAL_BIT       2
`define STBY_LSSTOP_BIT     3
`define STBY_CMPLS_BIT      4
`define STBY_CTRL_W         5

// ****************************************************************
// timing
// ****************************************************************
`define STBY_CLK_MHZ        250
`define STBY_HALT_VEC_MIN   11
`define STBY_HALT_VEC_MAX   13
`define STBY_HALT_SEQ_MIN   3
`define STBY_HALT_SEQ_MAX   5
`define STBY_OPSTOP_MIN_NS  17000
`define STBY_OPSTOP_TYP_NS  34000
`define STBY_OPSTOP_MAX_NS  67000
`define STBY_OPTRD_MIN_NS   277000
`define STBY_OPTRD_TYP_NS   544000
`define STBY_OPTRD_MAX_NS   1075000
`define STBY_SETTLE_EXP0    10
`define STBY_SETTLE_EXP1    12
`define STBY_SETTLE_EXP2    15
`define STBY_SETTLE_EXP3    17

`endif

// *** design/stby_pkg.sv ***
package stby_pkg;
    localparam int STBY_TW = 18;

    typedef logic [STBY_TW-1:0] stby_cnt_t;

    typedef enum logic [3:0] {
        ST_BOOT,
        ST_OPTREAD,
        ST_RUN,
        ST_LIGHT,
        ST_WAKE,
        ST_DEEP,
        ST_DSTOP,
        ST_SETTLE,
        ST_RESUME
    } stby_state_t;
endpackage : stby_pkg

// *** design/stby_tmr_if.sv ***
`timescale 1ns/1ps
interface stby_tmr_if;
    import stby_pkg::*;
    logic      load;
    stby_cnt_t value;
    logic      done;

    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface : stby_tmr_if

// *** design/stby_timer.sv ***
`timescale 1ns/1ps
// ****************************************************************
// wait counter: done pulses value cycles after the load cycle
// ****************************************************************
module stby_timer
    import stby_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    stby_tmr_if.tmr   tif
);
    stby_cnt_t cnt_q;
    stby_cnt_t cnt_d;
    wire logic running;

    assign running  = (cnt_q != '0);
    assign tif.done = (cnt_q == stby_cnt_t'(1));
    assign cnt_d    = tif.load ? tif.value : (running ? cnt_q - stby_cnt_t'(1) : cnt_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // a reload while counting restarts the wait
    a_done_single : assert property (@(posedge clk) disable iff (sys_rst)
        tif.done && !tif.load |=> !tif.done)
        else $error("wait counter done held longer than one cycle");
endmodule : stby_timer

// *** design/stby_ctrl.sv ***
`timescale 1ns/1ps
`include "stby_regs.svh"
// Function
// - halt instruction enters light standby; cpu clock gated, oscillator keeps running.
// - in light standby cpu idles and port latches hold their values.
// - unmasked pending request at a halt instruction leaves standby at once.
// - any unmasked maskable request releases light standby.
// - wake vectors with interrupts enabled, else next instruction; masked stays.
// - light wake with vectored servicing waits 11 to 13 clocks.
// - light wake without vectored servicing waits 3 to 5 clocks.
// - reset releases light standby and runs the normal reset flow.
// - after reset release operation stays stopped while option data is read.
// - stop instruction enters deep standby; oscillator halts, cpu and ports frozen.
// - leaving deep standby keeps operation stopped 17 to 67 us.
// - crystal clock adds the selected settle wait before resuming.
// - only compare timer, voltage detector, external requests release deep standby.
// - compare timer wakes deep standby only on low-speed clock by 2^7.
// - deep wake by interrupt waits settle, then vectors or continues.
// - reset releases deep standby; reset flow runs after settle time.
// - pending unmasked request at stop resumes right after the stop time; here crystal clock adds the settle wait first.
// - settle select codes 0..3 give 2^10, 2^12, 2^15, 2^17 clocks.
// - settle wait only with crystal clock, none with internal or external.
// - registers, memory, latches and buffers are kept through both standbys.
module stby_ctrl
    import stby_pkg::*;
#(
    parameter int              NIRQ            = 8,
    parameter logic [NIRQ-1:0] DEEP_WAKE_MASK  = 8'h0E,
    parameter int              CMP_IDX         = 1,
    parameter int              OPSTOP_CYC      = (`STBY_OPSTOP_TYP_NS * `STBY_CLK_MHZ + 999) / 1000,
    parameter int              OPTRD_CYC       = (`STBY_OPTRD_TYP_NS * `STBY_CLK_MHZ + 999) / 1000,
    parameter int              SETTLE2_CYC     = 1 << `STBY_SETTLE_EXP2,
    parameter int              SETTLE3_CYC     = 1 << `STBY_SETTLE_EXP3
)(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic [11:0]     paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata_q,
    output logic                 pready_q,
    output logic                 pslverr_q,
    input  wire logic            halt_exec,
    input  wire logic            stop_exec,
    input  wire logic [NIRQ-1:0] irq_req,
    input  wire logic [NIRQ-1:0] interrupt_mask_flag,
    input  wire logic            global_interrupt_enable,
    input  wire logic            reset_req,
    output logic                 cpu_clk_en_q,
    output logic                 sys_osc_en_q,
    output logic                 sys_periph_en_q,
    output logic                 ls_periph_en_q,
    output logic                 port_hold_q,
    output logic                 core_reset_q,
    output logic                 vector_req_q,
    output logic                 resume_next_q,
    output stby_state_t          state_q
);
    localparam int HALT_VEC_CYC = (`STBY_HALT_VEC_MIN + `STBY_HALT_VEC_MAX) / 2;
    localparam int HALT_SEQ_CYC = (`STBY_HALT_SEQ_MIN + `STBY_HALT_SEQ_MAX) / 2;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic stby_cnt_t to_cnt(input int v);
        to_cnt = v[STBY_TW-1:0];
    endfunction : to_cnt

    function automatic stby_cnt_t settle_cycles(input logic [1:0] sel);
        case (sel)
            2'd0:    settle_cycles = to_cnt(1 << `STBY_SETTLE_EXP0);
            2'd1:    settle_cycles = to_cnt(1 << `STBY_SETTLE_EXP1);
            2'd2:    settle_cycles = to_cnt(SETTLE2_CYC);
            default: settle_cycles = to_cnt(SETTLE3_CYC);
        endcase
    endfunction : settle_cycles

    function automatic logic in_stby(input stby_state_t s);
        in_stby = (s == ST_LIGHT) || (s == ST_WAKE) || (s == ST_DEEP) ||
                  (s == ST_DSTOP) || (s == ST_SETTLE) || (s == ST_RESUME);
    endfunction : in_stby

    function automatic logic in_deep(input stby_state_t s);
        in_deep = (s == ST_DEEP) || (s == ST_DSTOP) || (s == ST_SETTLE);
    endfunction : in_deep

    // ****************************************************************
    // reset request synchroniser
    // ****************************************************************
    logic [2:0] rst_sync_q;
    logic       reset_lvl_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sync_q <= 3'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[1:0], reset_req};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_lvl_q <= 1'b0;
        end else if (rst_sync_q[1] == rst_sync_q[2]) begin
            reset_lvl_q <= rst_sync_q[2];
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    logic [`STBY_CTRL_W-1:0] ctrl_q;
    wire logic               acc_ph;
    wire logic               acc_done;
    wire logic               hit_ctrl;
    wire logic               hit_stat;
    wire logic [31:0]        rd_mux;
    wire logic [1:0]         osc_settle_time_select;
    wire logic               xtal_src;
    wire logic               ls_stop;
    wire logic               cmp_lowspd;

    assign acc_ph     = psel && penable && !pready_q;
    assign acc_done   = psel && penable && pready_q;
    assign hit_ctrl   = (paddr == `STBY_CTRL_OFS);
    assign hit_stat   = (paddr == `STBY_STAT_OFS);
    assign osc_settle_time_select       = ctrl_q[`STBY_OSC_SETTLE_TIME_SELECT_MSB:`STBY_OSC_SETTLE_TIME_SELECT_LSB];
    assign xtal_src   = ctrl_q[`STBY_XTAL_BIT];
    assign ls_stop    = ctrl_q[`STBY_LSSTOP_BIT];
    assign cmp_lowspd = ctrl_q[`STBY_CMPLS_BIT];
    assign rd_mux     = hit_ctrl ? {27'h000_0000, ctrl_q} :
                        hit_stat ? {23'h00_0000, ls_periph_en_q, port_hold_q, reset_lvl_q,
                                    cpu_clk_en_q, 1'b0, state_q} : 32'h0000_0000;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= acc_ph;
            pslverr_q <= acc_ph && !hit_ctrl && !hit_stat;
            prdata_q  <= (acc_ph && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `STBY_CTRL_RST;
        end else if (acc_done && pwrite && hit_ctrl) begin
            ctrl_q <= pwdata[`STBY_CTRL_W-1:0];
        end
    end

    // ****************************************************************
    // wake qualification
    // ****************************************************************
    logic [NIRQ-1:0] deep_cap;
    wire logic       unmasked_any;
    wire logic       deep_wake_any;

    assign unmasked_any = |(irq_req & ~interrupt_mask_flag);

    // compare timer only on low-speed clock
    always_comb begin
        deep_cap          = DEEP_WAKE_MASK;
        deep_cap[CMP_IDX] = DEEP_WAKE_MASK[CMP_IDX] && cmp_lowspd;
    end

    assign deep_wake_any = |(irq_req & ~interrupt_mask_flag & deep_cap);

    // ****************************************************************
    // sequencer
    // ****************************************************************
    stby_tmr_if tif ();

    stby_timer u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tif     (tif)
    );

    stby_state_t state_d;
    logic        wake_vec_q;
    logic        wake_vec_d;
    logic        rst_pend_q;
    logic        rst_pend_d;
    logic        vec_d;
    logic        res_d;
    logic        ld;
    stby_cnt_t   ld_val;
    wire logic   tdone;
    wire stby_cnt_t wake_cyc;

    assign tdone     = tif.done;
    assign tif.load  = ld;
    assign tif.value = ld_val;
    assign wake_cyc  = global_interrupt_enable ? to_cnt(HALT_VEC_CYC) : to_cnt(HALT_SEQ_CYC);

    always_comb begin
        state_d    = state_q;
        wake_vec_d = wake_vec_q;
        rst_pend_d = rst_pend_q;
        vec_d      = 1'b0;
        res_d      = 1'b0;
        ld         = 1'b0;
        ld_val     = '0;
        case (state_q)
            ST_BOOT: begin
                ld      = !reset_lvl_q;
                ld_val  = to_cnt(OPTRD_CYC);
                state_d = reset_lvl_q ? ST_BOOT : ST_OPTREAD;
            end
            ST_OPTREAD: begin
                if (tdone) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (reset_lvl_q) begin
                    state_d = ST_BOOT;
                end else if (halt_exec) begin
                    // enter light or leave at once
                    wake_vec_d = global_interrupt_enable;
                    if (unmasked_any) begin
                        ld      = 1'b1;
                        ld_val  = wake_cyc;
                        state_d = ST_WAKE;
                    end else begin
                        state_d = ST_LIGHT;
                    end
                end else if (stop_exec) begin
                    // enter deep or run the stop time
                    wake_vec_d = global_interrupt_enable;
                    rst_pend_d = 1'b0;
                    if (unmasked_any) begin
                        ld      = 1'b1;
                        ld_val  = to_cnt(OPSTOP_CYC);
                        state_d = ST_DSTOP;
                    end else begin
                        state_d = ST_DEEP;
                    end
                end
            end
            ST_LIGHT: begin
                if (reset_lvl_q) begin
                    state_d = ST_BOOT;
                end else if (unmasked_any) begin
                    wake_vec_d = global_interrupt_enable;
                    ld         = 1'b1;
                    ld_val     = wake_cyc;
                    state_d    = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (reset_lvl_q) begin
                    state_d = ST_BOOT;
                end else if (tdone) begin
                    vec_d   = wake_vec_q;
                    res_d   = !wake_vec_q;
                    state_d = ST_RUN;
                end
            end
            ST_DEEP: begin
                // reset leaves via stop and settle time
                if (reset_lvl_q || deep_wake_any) begin
                    rst_pend_d = reset_lvl_q;
                    wake_vec_d = global_interrupt_enable;
                    ld         = 1'b1;
                    ld_val     = to_cnt(OPSTOP_CYC);
                    state_d    = ST_DSTOP;
                end
            end
            ST_DSTOP: begin
                rst_pend_d = rst_pend_q || reset_lvl_q;
                if (tdone) begin
                    if (xtal_src) begin
                        ld      = 1'b1;
                        ld_val  = settle_cycles(osc_settle_time_select);
                        state_d = ST_SETTLE;
                    end else begin
                        state_d = ST_RESUME;
                    end
                end
            end
            ST_SETTLE: begin
                rst_pend_d = rst_pend_q || reset_lvl_q;
                if (tdone) begin
                    state_d = ST_RESUME;
                end
            end
            ST_RESUME: begin
                rst_pend_d = 1'b0;
                if (rst_pend_q || reset_lvl_q) begin
                    state_d = ST_BOOT;
                end else begin
                    vec_d   = wake_vec_q;
                    res_d   = !wake_vec_q;
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q    <= ST_BOOT;
            wake_vec_q <= 1'b0;
            rst_pend_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            wake_vec_q <= wake_vec_d;
            rst_pend_q <= rst_pend_d;
        end
    end

    // ****************************************************************
    // clock and hold outputs
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_clk_en_q    <= 1'b0;
            sys_osc_en_q    <= 1'b1;
            sys_periph_en_q <= 1'b0;
            ls_periph_en_q  <= 1'b0;
            port_hold_q     <= 1'b0;
            core_reset_q    <= 1'b1;
            vector_req_q    <= 1'b0;
            resume_next_q   <= 1'b0;
        end else begin
            cpu_clk_en_q    <= (state_d == ST_RUN);
            sys_osc_en_q    <= (state_d != ST_DEEP);
            sys_periph_en_q <= !in_deep(state_d) && (state_d != ST_BOOT) && (state_d != ST_OPTREAD);
            ls_periph_en_q  <= !(ls_stop && in_stby(state_d)) && (state_d != ST_BOOT);
            port_hold_q     <= in_stby(state_d);
            core_reset_q    <= (state_d == ST_BOOT) || (state_d == ST_OPTREAD);
            vector_req_q    <= vec_d;
            resume_next_q   <= res_d;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_halt_idle;
        state_q == ST_RUN && halt_exec && !reset_lvl_q;
    endsequence

    sequence s_light_entry_vec;
        $rose(state_q == ST_WAKE) && wake_vec_q && !reset_lvl_q;
    endsequence

    sequence s_light_entry_seq;
        $rose(state_q == ST_WAKE) && !wake_vec_q && !reset_lvl_q;
    endsequence

    a_halt_gates_clk : assert property (
        s_halt_idle ##0 !unmasked_any |=> state_q == ST_LIGHT && !cpu_clk_en_q && sys_osc_en_q)
        else $error("halt did not gate cpu clock");

    a_light_holds_port : assert property (
        state_q == ST_LIGHT |-> port_hold_q && !cpu_clk_en_q)
        else $error("ports not held in light standby");

    a_pending_halt : assert property (
        s_halt_idle ##0 unmasked_any |=> state_q == ST_WAKE)
        else $error("pending request did not skip light standby");

    a_masked_stays : assert property (
        state_q == ST_LIGHT && !unmasked_any && !reset_lvl_q |=> state_q == ST_LIGHT)
        else $error("light standby left with no unmasked request");

    a_wake_vec_wait : assert property (
        s_light_entry_vec |-> !vector_req_q[*8] ##5 vector_req_q)
        else $error("vectored wake wait wrong");

    a_wake_seq_wait : assert property (
        s_light_entry_seq |-> ##4 resume_next_q)
        else $error("sequential wake wait wrong");

    a_light_reset : assert property (
        state_q == ST_LIGHT && reset_lvl_q |=> state_q == ST_BOOT ##1 core_reset_q)
        else $error("reset did not release light standby");

    a_deep_osc_off : assert property (
        state_q == ST_DEEP |-> !sys_osc_en_q && !sys_periph_en_q && port_hold_q)
        else $error("oscillator running in deep standby");

    a_deep_sources : assert property (
        state_q == ST_DEEP && !deep_wake_any && !reset_lvl_q |=> state_q == ST_DEEP)
        else $error("deep standby left without a qualified source");

    a_no_settle_int : assert property (
        state_q == ST_DSTOP && tdone && !xtal_src |=> state_q == ST_RESUME)
        else $error("settle wait inserted without crystal clock");

    a_apb_one_wait : assert property (
        acc_ph |=> pready_q ##1 !pready_q)
        else $error("apb answer not one cycle");
endmodule : stby_ctrl

// *** bench/stby_core_model.sv ***
`timescale 1ns/1ps
// ****************************************
// core and interrupt request side
// ****************************************
module stby_core_model (
    input  wire logic       clk,
    input  wire logic       ack,
    output logic            halt_exec,
    output logic            stop_exec,
    output logic [7:0]      irq_req,
    output logic [7:0]      interrupt_mask_flag,
    output logic            gie
);
    initial begin
        halt_exec = 1'b0;
        stop_exec = 1'b0;
        irq_req = 8'h00;
        interrupt_mask_flag = 8'h00;
        gie = 1'b0;
    end
    // serviced request is cleared by software
    always @(posedge clk) begin
        if (ack) begin
            irq_req <= 8'h00;
        end
    end
    task automatic exec(input logic stp);
        @(posedge clk);
        halt_exec <= ~stp;
        stop_exec <= stp;
        @(posedge clk);
        halt_exec <= 1'b0;
        stop_exec <= 1'b0;
    endtask : exec
endmodule : stby_core_model

// *** bench/standby_halt_stop_control_tb.sv ***
`timescale 1ns/1ps
// ****************************************
// standby controller bench
// ****************************************
module standby_halt_stop_control_tb;
    import stby_pkg::*;
    localparam int OS = 20;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reset_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        cpu_clk_en_q;
    logic        sys_osc_en_q;
    logic        sys_periph_en_q;
    logic        ls_periph_en_q;
    logic        port_hold_q;
    logic        core_reset_q;
    logic        vector_req_q;
    logic        resume_next_q;
    stby_state_t state_q;
    int          bad_count = 0;
    int          check_count = 0;
    int          seed = 32'h4bfb;
    int          n;
    logic [31:0] r;
    logic        e;
    logic        g;
    logic [4:0]  c;

    initial begin
        forever #2 clk = ~clk;
    end

    stby_core_model cm (.clk(clk), .ack(vector_req_q | resume_next_q), .halt_exec(), .stop_exec(),
        .irq_req(), .interrupt_mask_flag(), .gie());

    stby_ctrl #(.OPSTOP_CYC(OS), .OPTRD_CYC(30), .SETTLE2_CYC(40), .SETTLE3_CYC(50)) dut (
        .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .halt_exec(cm.halt_exec), .stop_exec(cm.stop_exec), .irq_req(cm.irq_req),
        .interrupt_mask_flag(cm.interrupt_mask_flag), .global_interrupt_enable(cm.gie),
        .reset_req(reset_req), .cpu_clk_en_q(cpu_clk_en_q), .sys_osc_en_q(sys_osc_en_q),
        .sys_periph_en_q(sys_periph_en_q), .ls_periph_en_q(ls_periph_en_q), .port_hold_q(port_hold_q),
        .core_reset_q(core_reset_q), .vector_req_q(vector_req_q), .resume_next_q(resume_next_q),
        .state_q(state_q));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready_q !== 1'b1);
        r = prdata_q;
        e = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_for(input logic run);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((run ? cpu_clk_en_q : (vector_req_q | resume_next_q)) !== 1'b1);
    endtask : wait_for

    function automatic int settle(input logic [2:0] cx);
        return !cx[2] ? 0 : cx[1:0] == 0 ? 1024 : cx[1:0] == 1 ? 4096 : cx[1:0] == 2 ? 40 : 50;
    endfunction : settle

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial begin
        #100_000;
        bad_count++;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        wait_for(1);
        chk(n >= 30, 1);
        c = $random(seed);
        apb(12'h000, 1, {27'h0, c});
        apb(12'h000, 0, 0);
        chk(r, {27'h0, c});
        apb(12'h004, 0, 0);
        chk(r[5:0], 6'h22);
        apb(12'h010, 0, 0);
        chk({e, r}, 33'h1_0000_0000);
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            g = $random(seed) ^ i[0];
            repeat (2) @(posedge clk);
            cm.gie <= g;
            cm.interrupt_mask_flag <= 8'h20;
            cm.irq_req <= (i == 2) ? 8'h01 : 8'h20;
            cm.exec(0);
            #1;
            chk(state_q, (i == 2) ? ST_WAKE : ST_LIGHT);
            if (i < 2) begin
                chk({cpu_clk_en_q, port_hold_q, sys_osc_en_q}, 3'b011);
                repeat (3) @(posedge clk);
                #1;
                chk(state_q, ST_LIGHT);
                @(posedge clk);
                cm.interrupt_mask_flag <= 8'h00;
                wait_for(0);
                chk(n, g ? 13 : 5);
            end else
                wait_for(0);
            chk({vector_req_q, resume_next_q, cpu_clk_en_q}, {g, !g, 1'b1});
        end
        $display("light standby done");
        for (int i = 0; i < 5; i++) begin
            c = {i[0], 1'($random(seed)), i < 4, 2'(i)};
            apb(12'h000, 1, {27'h0, c});
            if (i == 4)
                cm.irq_req <= 8'h08;
            cm.exec(1);
            #1;
            if (i < 4) begin
                chk({state_q, sys_osc_en_q, sys_periph_en_q, port_hold_q}, {ST_DEEP, 3'b001});
                chk(ls_periph_en_q, !c[3]);
                @(posedge clk);
                cm.irq_req <= c[4] ? 8'h01 : 8'h03;
                repeat (5) @(posedge clk);
                #1;
                chk(state_q, ST_DEEP);
                @(posedge clk);
                cm.irq_req <= c[4] ? 8'h02 : 8'h0B;
            end
            wait_for(0);
            chk(n >= OS + settle(c[2:0]) && n <= OS + settle(c[2:0]) + 6, 1);
        end
        $display("deep standby done");
        for (int j = 0; j < 2; j++) begin
            cm.exec(j[0]);
            reset_req <= 1'b1;
            repeat (8 + OS) @(posedge clk);
            #1;
            chk(core_reset_q, 1);
            @(posedge clk);
            reset_req <= 1'b0;
            wait_for(1);
            chk(n >= 30, 1);
        end
        $display("reset release done");
        finish_test;
    end
endmodule : standby_halt_stop_control_tb
